// file: common/gpp_pkg.sv
/*
 * gpp_pkg: constants, register map and carrier types for the fast parallel
 * i/o port. Assumes a 32-bit register port with byte enables and a single
 * system clock with synchronous reset.
 */
package gpp_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int LANE_W = 8;

    // ------------------------------------------------------------------
    // address fields
    // ------------------------------------------------------------------
    localparam int OFS_LSB = 2;
    localparam int OFS_W = 3;
    localparam int PORT_IDX_LSB = 5;
    localparam int PORT_IDX_W = 3;
    localparam int INT_IDX_LSB = 5;
    localparam int RGN_LSB = 7;
    localparam int RGN_W = 2;
    localparam int IDX_MSB = 11;
    localparam int IDX_LSB = 9;

    // region codes in addr[8:7]; port region is addr[8] == 0
    localparam logic [RGN_W-1:0] RGN_INT = 2'h2;
    localparam logic [RGN_W-1:0] RGN_SUM = 2'h3;

    // ------------------------------------------------------------------
    // per-port register offsets (word index inside a port block)
    // ------------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_DIR = 3'h0;
    localparam logic [OFS_W-1:0] OFS_OUT = 3'h1;
    localparam logic [OFS_W-1:0] OFS_MASK = 3'h2;
    localparam logic [OFS_W-1:0] OFS_PIN = 3'h3;
    localparam logic [OFS_W-1:0] OFS_SET = 3'h4;
    localparam logic [OFS_W-1:0] OFS_CLR = 3'h5;

    // ------------------------------------------------------------------
    // edge interrupt register offsets (word index inside an int block)
    // ------------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_RISE_EN = 3'h0;
    localparam logic [OFS_W-1:0] OFS_FALL_EN = 3'h1;
    localparam logic [OFS_W-1:0] OFS_RISE_ST = 3'h2;
    localparam logic [OFS_W-1:0] OFS_FALL_ST = 3'h3;
    localparam logic [OFS_W-1:0] OFS_WAKE_EN = 3'h4;
    localparam logic [OFS_W-1:0] OFS_SUM = 3'h0;

    // ------------------------------------------------------------------
    // interrupt-capable ports
    // ------------------------------------------------------------------
    localparam int NUM_INT = 2;
    localparam int INT_PORT0 = 0;
    localparam int INT_PORT1 = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DIR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OUT_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] EN_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ST_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0] be;
        logic wr;
        logic rd;
    } gpp_req_t;

endpackage

// file: hdl/gpp_port.sv
/*
 * gpp_port: general purpose parallel i/o ports with direction, set/clear,
 * masked group access, latch and pin readback, and edge interrupts on two
 * ports. Assumes pins are synchronous to sys_clk and a register master that
 * never waits and issues one-cycle strobes.
 */
`timescale 1ns/1ps

// How it works
// - port drives pins not claimed by peripherals
// - per-bit direction, changeable any time
// - reset makes all pins inputs
// - set and clear writes, ones act
// - read output latch and live pins
// - mask shields bits from group access
// - one write loads whole output latch
// - byte, halfword, word accesses by lanes
// - rising, falling or both edge interrupts
// - edges caught every cycle, no enable
// - enabled edge interrupt requests wake-up when its block's wake enable is set
module gpp_port #(
    parameter int NPORT = 6,
    parameter int W = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input gpp_pkg::gpp_req_t bus_req,
    output logic [gpp_pkg::DATA_W-1:0] rd_data,
    input wire logic [NPORT-1:0][W-1:0] func_sel,
    input wire logic [NPORT-1:0][W-1:0] pin_in,
    output logic [NPORT-1:0][W-1:0] pin_out,
    output logic [NPORT-1:0][W-1:0] pin_oe_n,
    output logic irq,
    output logic wake_req
);
    import gpp_pkg::*;

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (NPORT <= INT_PORT1) begin : g_chk_nport_lo
        $error("gpp_port: NPORT must include both interrupt ports");
    end
    if (NPORT > (1 << PORT_IDX_W)) begin : g_chk_nport_hi
        $error("gpp_port: NPORT exceeds the port index field");
    end
    if (W < 1) begin : g_chk_w_lo
        $error("gpp_port: W must be at least one");
    end
    if (W > DATA_W) begin : g_chk_w_hi
        $error("gpp_port: W wider than the data bus");
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [OFS_W-1:0] ofs;
    logic [PORT_IDX_W-1:0] pidx;
    logic [RGN_W-1:0] rgn;
    logic port_rgn;
    logic int_idx;
    logic hi_zero;
    logic [DATA_W-1:0] lane_m;
    logic [W-1:0] bmw;
    logic [W-1:0] wd;

    // address fields
    assign ofs = bus_req.addr[OFS_LSB +: OFS_W];
    assign pidx = bus_req.addr[PORT_IDX_LSB +: PORT_IDX_W];
    assign rgn = bus_req.addr[RGN_LSB +: RGN_W];
    assign port_rgn = ~rgn[RGN_W-1];
    assign int_idx = bus_req.addr[INT_IDX_LSB];
    assign hi_zero = bus_req.addr[IDX_MSB:IDX_LSB] == '0;

    // byte lanes expanded to a bit mask
    always_comb begin
        lane_m = '0;
        for (int b = 0; b < BE_W; b++) begin
            lane_m[b*LANE_W +: LANE_W] = {LANE_W{bus_req.be[b]}};
        end
    end

    assign bmw = lane_m[W-1:0];
    assign wd = bus_req.wdata[W-1:0];

    // ------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------
    logic [W-1:0] dir_r [NPORT];
    logic [W-1:0] out_r [NPORT];
    logic [W-1:0] mask_r [NPORT];

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic hit;
        logic [W-1:0] grp;

        assign hit = bus_req.wr && hi_zero && port_rgn && pidx == PORT_IDX_W'(p);
        assign grp = bmw & ~mask_r[p];

        // direction
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                dir_r[p] <= DIR_RST[W-1:0];
            end else if (hit && ofs == OFS_DIR) begin
                dir_r[p] <= (dir_r[p] & ~bmw) | (wd & bmw);
            end
        end

        // mask
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                mask_r[p] <= MASK_RST[W-1:0];
            end else if (hit && ofs == OFS_MASK) begin
                mask_r[p] <= (mask_r[p] & ~bmw) | (wd & bmw);
            end
        end

        // output latch
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                out_r[p] <= OUT_RST[W-1:0];
            end else if (hit) begin
                unique case (ofs)
                    OFS_OUT: out_r[p] <= (out_r[p] & ~bmw) | (wd & bmw);
                    OFS_PIN: out_r[p] <= (out_r[p] & ~grp) | (wd & grp);
                    OFS_SET: out_r[p] <= out_r[p] | (wd & grp);
                    OFS_CLR: out_r[p] <= out_r[p] & ~(wd & grp);
                    default: out_r[p] <= out_r[p];
                endcase
            end
        end

        // pin drive, released where a peripheral owns the pin
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                pin_oe_n[p] <= '1;
            end else begin
                pin_oe_n[p] <= ~dir_r[p] | func_sel[p];
            end
        end

        assign pin_out[p] = out_r[p];
    end

    // ------------------------------------------------------------------
    // edge interrupts
    // ------------------------------------------------------------------
    logic [W-1:0] ren_r [NUM_INT];
    logic [W-1:0] fen_r [NUM_INT];
    logic [W-1:0] rst_r [NUM_INT];
    logic [W-1:0] fst_r [NUM_INT];
    logic [W-1:0] prev_r [NUM_INT];
    logic [NUM_INT-1:0] wken_r;
    logic [NUM_INT-1:0] pend;
    logic [NUM_INT-1:0] wk_pend;
    logic prime_r;

    // first sample after reset is history only, never an edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prime_r <= 1'b0;
        end else begin
            prime_r <= 1'b1;
        end
    end

    for (genvar k = 0; k < NUM_INT; k++) begin : g_int
        localparam int IP = (k == 0) ? INT_PORT0 : INT_PORT1;
        logic hit;
        logic [W-1:0] rise_ev;
        logic [W-1:0] fall_ev;
        logic [W-1:0] clr;

        assign hit = bus_req.wr && hi_zero && rgn == RGN_INT && int_idx == 1'(k);
        assign clr = wd & bmw;
        assign rise_ev = pin_in[IP] & ~prev_r[k] & {W{prime_r}};
        assign fall_ev = ~pin_in[IP] & prev_r[k] & {W{prime_r}};

        // previous pin sample
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                prev_r[k] <= '0;
            end else begin
                prev_r[k] <= pin_in[IP];
            end
        end

        // rising edge selects
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                ren_r[k] <= EN_RST[W-1:0];
            end else if (hit && ofs == OFS_RISE_EN) begin
                ren_r[k] <= (ren_r[k] & ~bmw) | (wd & bmw);
            end
        end

        // falling edge selects
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                fen_r[k] <= EN_RST[W-1:0];
            end else if (hit && ofs == OFS_FALL_EN) begin
                fen_r[k] <= (fen_r[k] & ~bmw) | (wd & bmw);
            end
        end

        // wake enable
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                wken_r[k] <= 1'b0;
            end else if (hit && ofs == OFS_WAKE_EN && bus_req.be[0]) begin
                wken_r[k] <= bus_req.wdata[0];
            end
        end

        // sticky flags, a new edge beats a same-cycle clear
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                rst_r[k] <= ST_RST[W-1:0];
            end else if (hit && ofs == OFS_RISE_ST) begin
                rst_r[k] <= (rst_r[k] & ~clr) | rise_ev;
            end else begin
                rst_r[k] <= rst_r[k] | rise_ev;
            end
        end

        // falling edge flags
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                fst_r[k] <= ST_RST[W-1:0];
            end else if (hit && ofs == OFS_FALL_ST) begin
                fst_r[k] <= (fst_r[k] & ~clr) | fall_ev;
            end else begin
                fst_r[k] <= fst_r[k] | fall_ev;
            end
        end

        assign pend[k] = |((rst_r[k] & ren_r[k]) | (fst_r[k] & fen_r[k]));
        assign wk_pend[k] = pend[k] & wken_r[k];
    end

    // ------------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |pend;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= |wk_pend;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hi_zero && port_rgn && int'(pidx) < NPORT) begin
            unique case (ofs)
                OFS_DIR: rd_mux = DATA_W'(dir_r[pidx]);
                OFS_OUT: rd_mux = DATA_W'(out_r[pidx]);
                OFS_MASK: rd_mux = DATA_W'(mask_r[pidx]);
                OFS_PIN: rd_mux = DATA_W'(pin_in[pidx] & ~mask_r[pidx]);
                OFS_SET: rd_mux = DATA_W'(out_r[pidx]);
                OFS_CLR: rd_mux = '0;
                default: rd_mux = '0;
            endcase
        end else if (hi_zero && rgn == RGN_INT) begin
            unique case (ofs)
                OFS_RISE_EN: rd_mux = DATA_W'(ren_r[int_idx]);
                OFS_FALL_EN: rd_mux = DATA_W'(fen_r[int_idx]);
                OFS_RISE_ST: rd_mux = DATA_W'(rst_r[int_idx]);
                OFS_FALL_ST: rd_mux = DATA_W'(fst_r[int_idx]);
                OFS_WAKE_EN: rd_mux = DATA_W'(wken_r[int_idx]);
                default: rd_mux = '0;
            endcase
        end else if (hi_zero && rgn == RGN_SUM && ofs == OFS_SUM) begin
            rd_mux = DATA_W'(pend);
        end
    end

    // ------------------------------------------------------------------
    // read data register, valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (bus_req.rd) begin
            rd_data <= rd_mux & lane_m;
        end else begin
            rd_data <= '0;
        end
    end

endmodule

// file: tb/gpp_port_props.sv
/* gpp_port_props: port-level checks of the i/o port.
   assumes bind into gpp_port, one clock, srst synchronous. */
`timescale 1ns/1ps
module gpp_port_props #(
    parameter int NPORT = 6,
    parameter int W = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input gpp_pkg::gpp_req_t bus_req,
    input wire logic [gpp_pkg::DATA_W-1:0] rd_data,
    input wire logic [NPORT-1:0][W-1:0] func_sel,
    input wire logic [NPORT-1:0][W-1:0] pin_in,
    input wire logic [NPORT-1:0][W-1:0] pin_out,
    input wire logic [NPORT-1:0][W-1:0] pin_oe_n,
    input wire logic irq,
    input wire logic wake_req
);
    import gpp_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    reset_inputs_a: assert property ($fell(srst) |-> &pin_oe_n)
        else $error("pins driven after reset");
    reset_irq_a: assert property ($fell(srst) |-> !irq && !wake_req)
        else $error("interrupt outputs set after reset");
    read_idle_a: assert property (!bus_req.rd |=> rd_data == '0)
        else $error("read data outside read slot");
    lane_zero_a: assert property (bus_req.rd && !bus_req.be[3] |=> rd_data[31:24] == 8'h00)
        else $error("disabled lane not zero");
    func_release_a: assert property (1'b1 |=> (pin_oe_n & $past(func_sel)) == $past(func_sel))
        else $error("peripheral pin driven by port");
    dir_hold_a: assert property (!bus_req.wr ##1 $stable(func_sel) |=> $stable(pin_oe_n))
        else $error("direction changed without write");
    latch_hold_a: assert property (!bus_req.wr ##1 !bus_req.wr |=> $stable(pin_out))
        else $error("latch changed without write");
    wake_gate_a: assert property (wake_req |-> irq)
        else $error("wake without interrupt");
    irq_cause_a: assert property ($rose(irq) |->
        $past(bus_req.wr, 2) || $past(pin_in, 2) != $past(pin_in, 3))
        else $error("interrupt without edge or write");
endmodule
bind gpp_port gpp_port_props #(.NPORT(NPORT), .W(W)) u_gpp_port_props (
    .sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .func_sel(func_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq(irq), .wake_req(wake_req));

// file: tb/gpp_board.sv
/* gpp_board: board circuitry on the port pins.
   assumes pin_oe_n low while the port drives a pin. */
`timescale 1ns/1ps
module gpp_board #(
    parameter int NPORT = 6,
    parameter int W = 32
) (
    input wire logic [NPORT-1:0][W-1:0] pin_out,
    input wire logic [NPORT-1:0][W-1:0] pin_oe_n,
    input wire logic [NPORT-1:0][W-1:0] ext_drv,
    output logic [NPORT-1:0][W-1:0] pin_in
);
    // driven pins read the latch, released pins the outside source
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_drv & pin_oe_n);
endmodule

// file: tb/gpp_port_tb_top.sv
/* gpp_port_tb_top: register-level tests of the i/o port.
   assumes gpp_pkg, the board model and one 10 MHz clock. */
`timescale 1ns/1ps
module gpp_port_tb_top;
    import gpp_pkg::*;
    localparam int NP = 6;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    gpp_req_t bus_req = '0;
    logic [DATA_W-1:0] rd_data;
    logic [NP-1:0][31:0] func_sel = '0;
    logic [NP-1:0][31:0] ext_drv = '0;
    logic [NP-1:0][31:0] pin_in, pin_out, pin_oe_n;
    logic irq, wake_req;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    gpp_port #(.NPORT(NP), .W(32)) u_gpp_port (.sys_clk(sys_clk), .srst(srst),
        .bus_req(bus_req), .rd_data(rd_data), .func_sel(func_sel), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq), .wake_req(wake_req));
    gpp_board #(.NPORT(NP), .W(32)) u_gpp_board (.pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .ext_drv(ext_drv), .pin_in(pin_in));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wr(input int p, input int o, input logic [31:0] d, input logic [3:0] be = 4'hf);
        @(posedge sys_clk);
        bus_req <= '{addr: ADDR_W'(p * 32 + o * 4), wdata: d, be: be, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input int p, input int o, input logic [31:0] e, input logic [3:0] be = 4'hf);
        @(posedge sys_clk);
        bus_req <= '{addr: ADDR_W'(p * 32 + o * 4), wdata: '0, be: be, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk_word(rd_data, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        ext_drv[0] = 32'h1234_5600;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        step(1);
        chk_word(pin_oe_n[0], 32'hffff_ffff);
        rd(0, OFS_DIR, 32'h0);
        wr(0, OFS_DIR, 32'hff);
        wr(0, OFS_OUT, 32'ha5);
        step(2);
        rd(0, OFS_PIN, 32'h1234_56a5);
        rd(0, OFS_OUT, 32'ha5);
        wr(0, OFS_SET, 32'hf00);
        wr(0, OFS_CLR, 32'h5);
        rd(0, OFS_OUT, 32'hfa0);
        wr(0, OFS_MASK, 32'hf0);
        wr(0, OFS_SET, 32'hff);
        rd(0, OFS_OUT, 32'hfaf);
        step(2);
        rd(0, OFS_PIN, 32'h1234_560f);
        wr(0, OFS_PIN, 32'h0);
        rd(0, OFS_OUT, 32'ha0);
        wr(0, OFS_MASK, 32'h0);
        wr(0, OFS_OUT, 32'hffff_ffff, 4'h2);
        rd(0, OFS_OUT, 32'ha0, 4'h1);
        rd(0, OFS_OUT, 32'hffa0);
        @(posedge sys_clk);
        func_sel[0][1] <= 1'b1;
        step(2);
        chk_flag(pin_oe_n[0][1], 1'b1);
        chk_flag(pin_oe_n[0][0], 1'b0);
        wr(0, OFS_DIR, 32'h0);
        step(2);
        chk_word(pin_oe_n[0], 32'hffff_ffff);
        rd(8, OFS_FALL_ST, 32'haf);
        wr(8, OFS_RISE_ST, 32'hffff_ffff);
        wr(8, OFS_FALL_ST, 32'hffff_ffff);
        rd(8, OFS_RISE_ST, 32'h0);
        wr(8, OFS_RISE_EN, 32'h1);
        wr(9, OFS_RISE_EN, 32'h20);
        wr(9, OFS_FALL_EN, 32'h20);
        wr(9, OFS_WAKE_EN, 32'h1);
        ext_drv[0][3:0] <= 4'h5;
        step(3);
        chk_flag(irq, 1'b1);
        chk_flag(wake_req, 1'b0);
        rd(8, OFS_RISE_ST, 32'h5);
        rd(12, OFS_SUM, 32'h1);
        wr(8, OFS_RISE_ST, 32'h1);
        step(2);
        chk_flag(irq, 1'b0);
        rd(8, OFS_RISE_ST, 32'h4);
        @(posedge sys_clk);
        ext_drv[2][5] <= 1'b1;
        step(3);
        chk_flag(wake_req, 1'b1);
        rd(9, OFS_RISE_ST, 32'h20);
        wr(9, OFS_RISE_ST, 32'h20);
        ext_drv[2][5] <= 1'b0;
        step(3);
        chk_flag(irq, 1'b1);
        rd(9, OFS_FALL_ST, 32'h20);
        wr(9, OFS_FALL_EN, 32'h0);
        step(2);
        chk_flag(irq, 1'b0);
        rd(9, OFS_FALL_ST, 32'h20);
        rd(16, 0, 32'h0);
        print_verdict();
    end
endmodule
